/* File: psir_map.vh */
// register offsets, field positions, reset values and timing counts
// for the power stage input retrigger block; definitions only
`ifndef PSIR_MAP_VH
`define PSIR_MAP_VH

// apb byte offsets, one aligned word each
`define PSIR_ADDR_W 8
`define PSIR_OFF_CTRL 8'h00
`define PSIR_OFF_ON_TIME 8'h04
`define PSIR_OFF_DEAD_TIME 8'h08
`define PSIR_OFF_RAMP_B_CMP 8'h0C
`define PSIR_OFF_IN_CTRL_A 8'h10
`define PSIR_OFF_IN_CTRL_B 8'h14
`define PSIR_OFF_STATUS 8'h18

// control register fields
`define PSIR_CTRL_RUN 0
`define PSIR_CTRL_RAMP_LO 1
`define PSIR_CTRL_RAMP_HI 2
`define PSIR_CTRL_ENH 3
`define PSIR_CTRL_RESET 4'h0

// timing registers: part a in [11:0], part b in [27:16]
`define PSIR_TA_LO 0
`define PSIR_TA_HI 11
`define PSIR_TB_LO 16
`define PSIR_TB_HI 27
`define PSIR_TIME_RESET 12'h001
`define PSIR_RB_RESET 16'h0000
`define PSIR_FRAC_LO 12
`define PSIR_FRAC_HI 15

// input control fields
`define PSIR_IN_MODE_LO 0
`define PSIR_IN_MODE_HI 3
`define PSIR_IN_POL 4
`define PSIR_IN_FILT 5
`define PSIR_IN_SRC 6
`define PSIR_IN_ASYNC 7
`define PSIR_IN_RESET 8'h00

// ramp modes
`define PSIR_RAMP_ONE 2'h0
`define PSIR_RAMP_TWO 2'h1
`define PSIR_RAMP_FOUR 2'h2
`define PSIR_RAMP_CENTER 2'h3

// input mode codes
`define PSIR_IMODE_NONE 4'h0
`define PSIR_IMODE_JUMP_WAIT 4'h1
`define PSIR_IMODE_EXEC_WAIT 4'h2
`define PSIR_IMODE_EDGE 4'h8
`define PSIR_IMODE_LAST_STD 4'h9
`define PSIR_IMODE_FIXED_KILL 4'hE

// input filter length in controller clocks
`define PSIR_FILT_CYCLES 4
// cycles per fractional frame
`define PSIR_FRAME_LEN 16

`endif

/* File: psir_input.v */
// one input module: source select, three-stage sync, optional filter,
// polarity and edge detect; also the clockless output kill path.
// assumes pins are asynchronous to clk; reset is already synchronised.
`timescale 1ns/100ps
`default_nettype none
`include "psir_map.vh"

module psir_input (
	input wire clk,
	input wire rst_n,
	input wire ce,
	input wire pin_raw,
	input wire comp_raw,
	input wire src_sel,
	input wire filt_en,
	input wire polarity,
	input wire async_en,
	output wire active,
	output wire event_edge,
	output wire kill_async
);
	reg s1;
	reg s2;
	reg s3;
	reg stable;
	reg [`PSIR_FILT_CYCLES-1:0] filt_sh;
	reg filtered;
	reg active_d;
	wire raw;
	wire level;
	wire next_filtered;

	// pick comparator or pin before the synchroniser
	assign raw = src_sel ? comp_raw : pin_raw;

	// three flops; a change counts once s2 and s3 agree
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			stable <= 1'b0;
		end else if (ce) begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				stable <= s3;
		end
	end

	// four-cycle filter
	// level only moves when four samples agree
	assign next_filtered = (&filt_sh) ? 1'b1 : ((|filt_sh) ? filtered : 1'b0);
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			filt_sh <= {`PSIR_FILT_CYCLES{1'b0}};
			filtered <= 1'b0;
			// reset polarity is low-active and the level resets low, so active starts high;
			// matching it here keeps a false edge out of the first cycle
			active_d <= 1'b1;
		end else if (ce) begin
			filt_sh <= {filt_sh[`PSIR_FILT_CYCLES-2:0], stable};
			filtered <= next_filtered;
			active_d <= active;
		end
	end

	// bypass when filter off
	// no extra delay without the filter
	assign level = filt_en ? filtered : stable;

	assign active = polarity ? level : ~level;
	assign event_edge = active & ~active_d;

	// clockless kill path
	// straight from the selected pin or comparator so a stopped clock still protects the stage
	assign kill_async = async_en & (polarity ? raw : ~raw);
endmodule
`default_nettype wire

/* File: psir_top.v */
// waveform sequencer of a two-output power stage with retrigger inputs,
// apb register slave and two input modules.
// assumes an apb master on clk and external retrigger/fault sources.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "psir_map.vh"

module psir_top (
	input wire clk,
	input wire reset_n,
	input wire ce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`PSIR_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [1:0] fault_input_pin,
	input wire [1:0] comparator_out,
	output wire wave_out_a,
	output wire wave_out_b
);
	localparam ST_DTA = 3'h0;
	localparam ST_OTA = 3'h1;
	localparam ST_DTB = 3'h2;
	localparam ST_OTB = 3'h3;
	localparam ST_WAITA = 3'h4;
	localparam ST_WAITB = 3'h5;

	reg rst_m;
	reg rst_n;
	reg [3:0] ctrl;
	reg [11:0] on_time_a;
	reg [11:0] on_time_b;
	reg [11:0] dead_time_a;
	reg [11:0] dead_time_b;
	reg [15:0] ramp_b_compare;
	reg [7:0] input_ctrl_a;
	reg [7:0] input_ctrl_b;
	reg [2:0] state;
	reg [2:0] next_state;
	reg [12:0] cnt;
	reg [12:0] next_cnt;
	reg [3:0] frame;
	reg [3:0] next_frame;
	reg wait_to_opp;
	reg next_wait_to_opp;
	reg pend_a;
	reg next_pend_a;
	reg pend_b;
	reg next_pend_b;
	reg out_a;
	reg out_b;
	reg [12:0] cur_len;
	reg stretch;
	reg [3:0] frame_rev;
	reg hit_a;
	reg hit_b;
	wire [1:0] in_active;
	wire [1:0] in_edge;
	wire [1:0] in_kill;
	wire [7:0] in_cfg [0:1];
	wire run;
	wire [1:0] ramp;
	wire enh;
	wire [3:0] frac;
	wire [3:0] mode_a;
	wire [3:0] mode_b;
	wire one_ramp;
	wire centered;
	wire last;
	wire acc;
	wire wr;
	wire addr_ok;

	// reset release through two flops
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_m <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_m <= 1'b1;
			rst_n <= rst_m;
		end
	end

	assign in_cfg[0] = input_ctrl_a;
	assign in_cfg[1] = input_ctrl_b;

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_in
			psir_input u_in (
				.clk(clk),
				.rst_n(rst_n),
				.ce(ce),
				.pin_raw(fault_input_pin[g]),
				.comp_raw(comparator_out[g]),
				.src_sel(in_cfg[g][`PSIR_IN_SRC]),
				.filt_en(in_cfg[g][`PSIR_IN_FILT]),
				.polarity(in_cfg[g][`PSIR_IN_POL]),
				.async_en(in_cfg[g][`PSIR_IN_ASYNC]),
				.active(in_active[g]),
				.event_edge(in_edge[g]),
				.kill_async(in_kill[g])
			);
		end
	endgenerate

	// apb slave: zero wait states, error on unmapped offsets
	assign pready = 1'b1;
	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign addr_ok = (paddr == `PSIR_OFF_CTRL) || (paddr == `PSIR_OFF_ON_TIME) ||
		(paddr == `PSIR_OFF_DEAD_TIME) || (paddr == `PSIR_OFF_RAMP_B_CMP) ||
		(paddr == `PSIR_OFF_IN_CTRL_A) || (paddr == `PSIR_OFF_IN_CTRL_B) ||
		(paddr == `PSIR_OFF_STATUS);
	assign pslverr = acc & ~addr_ok;

	// register writes take effect at the access edge
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= `PSIR_CTRL_RESET;
			on_time_a <= `PSIR_TIME_RESET;
			on_time_b <= `PSIR_TIME_RESET;
			dead_time_a <= `PSIR_TIME_RESET;
			dead_time_b <= `PSIR_TIME_RESET;
			ramp_b_compare <= `PSIR_RB_RESET;
			input_ctrl_a <= `PSIR_IN_RESET;
			input_ctrl_b <= `PSIR_IN_RESET;
		end else if (ce && wr) begin
			case (paddr)
				`PSIR_OFF_CTRL: ctrl <= pwdata[3:0];
				`PSIR_OFF_ON_TIME: begin
					on_time_a <= pwdata[`PSIR_TA_HI:`PSIR_TA_LO];
					on_time_b <= pwdata[`PSIR_TB_HI:`PSIR_TB_LO];
				end
				`PSIR_OFF_DEAD_TIME: begin
					dead_time_a <= pwdata[`PSIR_TA_HI:`PSIR_TA_LO];
					dead_time_b <= pwdata[`PSIR_TB_HI:`PSIR_TB_LO];
				end
				`PSIR_OFF_RAMP_B_CMP: ramp_b_compare <= pwdata[15:0];
				`PSIR_OFF_IN_CTRL_A: input_ctrl_a <= pwdata[7:0];
				`PSIR_OFF_IN_CTRL_B: input_ctrl_b <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// read data latched in the setup cycle, valid through access
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (ce && psel && !penable) begin
			case (paddr)
				`PSIR_OFF_CTRL: prdata <= {28'h000_0000, ctrl};
				`PSIR_OFF_ON_TIME: prdata <= {4'h0, on_time_b, 4'h0, on_time_a};
				`PSIR_OFF_DEAD_TIME: prdata <= {4'h0, dead_time_b, 4'h0, dead_time_a};
				`PSIR_OFF_RAMP_B_CMP: prdata <= {16'h0000, ramp_b_compare};
				`PSIR_OFF_IN_CTRL_A: prdata <= {24'h00_0000, input_ctrl_a};
				`PSIR_OFF_IN_CTRL_B: prdata <= {24'h00_0000, input_ctrl_b};
				`PSIR_OFF_STATUS: prdata <= {cnt, 5'h00, frame, 3'h0, in_active,
					state, wave_out_b, wave_out_a};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	assign run = ctrl[`PSIR_CTRL_RUN];
	assign ramp = ctrl[`PSIR_CTRL_RAMP_HI:`PSIR_CTRL_RAMP_LO];
	assign enh = ctrl[`PSIR_CTRL_ENH];
	assign frac = ramp_b_compare[`PSIR_FRAC_HI:`PSIR_FRAC_LO];
	assign mode_a = input_ctrl_a[`PSIR_IN_MODE_HI:`PSIR_IN_MODE_LO];
	assign mode_b = input_ctrl_b[`PSIR_IN_MODE_HI:`PSIR_IN_MODE_LO];
	assign one_ramp = (ramp == `PSIR_RAMP_ONE);
	assign centered = (ramp == `PSIR_RAMP_CENTER);

	// phase length; zero counts are run as one clock
	always @* begin
		// bit-reversed slot below d is stretched
		frame_rev = {frame[0], frame[1], frame[2], frame[3]};
		stretch = enh && (frame_rev < frac);
		case (state)
			ST_OTA: cur_len = {1'b0, on_time_a} + {12'h000, stretch};
			ST_DTB: cur_len = {1'b0, dead_time_b};
			ST_OTB: cur_len = {1'b0, on_time_b};
			default: cur_len = {1'b0, dead_time_a};
		endcase
		if (cur_len == 13'h0000)
			cur_len = 13'h0001;
	end
	assign last = (cnt >= cur_len - 13'h0001);

	// which inputs fire this cycle
	always @* begin
		// only modes 1, 2, 8 steer the sequence; others act as none
		// level for modes 1/2, edge for mode 8
		case (mode_a)
			`PSIR_IMODE_JUMP_WAIT: hit_a = in_active[0];
			`PSIR_IMODE_EXEC_WAIT: hit_a = in_active[0];
			`PSIR_IMODE_EDGE: hit_a = in_edge[0];
			default: hit_a = 1'b0;
		endcase
		case (mode_b)
			`PSIR_IMODE_JUMP_WAIT: hit_b = in_active[1];
			`PSIR_IMODE_EXEC_WAIT: hit_b = in_active[1];
			`PSIR_IMODE_EDGE: hit_b = in_edge[1];
			default: hit_b = 1'b0;
		endcase
		if (centered || !run) begin
			hit_a = 1'b0;
			hit_b = 1'b0;
		end
		// windows in two/four ramp; whole ramp in one ramp
		if (!one_ramp) begin
			if (state != ST_DTA && state != ST_OTA)
				hit_a = 1'b0;
			if (state != ST_DTB && state != ST_OTB)
				hit_b = 1'b0;
		end
		// a pending mode-2 sub-cycle is never cut short
		if (pend_a || pend_b || state == ST_WAITA || state == ST_WAITB) begin
			hit_a = 1'b0;
			hit_b = 1'b0;
		end
	end

	// sequencer next state
	always @* begin
		next_state = state;
		next_cnt = cnt + 13'h0001;
		next_frame = frame;
		next_wait_to_opp = wait_to_opp;
		next_pend_a = pend_a;
		next_pend_b = pend_b;
		if (!run) begin
			next_state = ST_DTA;
			next_cnt = 13'h0000;
			next_frame = 4'h0;
			next_pend_a = 1'b0;
			next_pend_b = 1'b0;
		end else if (hit_a || hit_b) begin
			next_cnt = 13'h0000;
			if (one_ramp) begin
				next_state = ST_DTA;
				if ((hit_a && mode_a == `PSIR_IMODE_JUMP_WAIT) ||
					(hit_b && mode_b == `PSIR_IMODE_JUMP_WAIT)) begin
					next_state = hit_a ? ST_WAITA : ST_WAITB;
					next_wait_to_opp = 1'b0;
				end
			end else if (hit_a) begin
				next_state = ST_DTB;
				// release a, wait, then dead b
				if (mode_a == `PSIR_IMODE_JUMP_WAIT) begin
					next_state = ST_WAITA;
					next_wait_to_opp = 1'b1;
				end
				// run dead b at once, wait later
				if (mode_a == `PSIR_IMODE_EXEC_WAIT)
					next_pend_a = 1'b1;
			end else begin
				next_state = ST_DTA;
				// release b, wait, then dead a
				if (mode_b == `PSIR_IMODE_JUMP_WAIT) begin
					next_state = ST_WAITB;
					next_wait_to_opp = 1'b1;
				end
				// run dead a at once, wait later
				if (mode_b == `PSIR_IMODE_EXEC_WAIT)
					next_pend_b = 1'b1;
			end
		end else begin
			case (state)
				ST_WAITA: begin
					next_cnt = 13'h0000;
					if (!in_active[0]) begin
						next_state = wait_to_opp ? ST_DTB : ST_DTA;
						next_wait_to_opp = 1'b0;
					end
				end
				ST_WAITB: begin
					next_cnt = 13'h0000;
					if (!in_active[1]) begin
						next_state = wait_to_opp ? ST_DTA : ST_DTB;
						next_wait_to_opp = 1'b0;
					end
				end
				default: begin
					if (last) begin
						next_cnt = 13'h0000;
						next_state = state + 3'h1;
						if (state == ST_OTA)
							next_frame = frame + 4'h1;
						if (state == ST_OTB) begin
							next_state = ST_DTA;
							// wait only after full b sub-cycle
							if (pend_a) begin
								next_pend_a = 1'b0;
								next_state = in_active[0] ? ST_WAITA : ST_DTA;
							end
						end
						if (state == ST_OTA && pend_b) begin
							// wait only after full a sub-cycle
							next_pend_b = 1'b0;
							next_state = in_active[1] ? ST_WAITB : ST_DTB;
						end
					end
				end
			endcase
		end
	end

	// sequencer and outputs registered; ce freezes all
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_DTA;
			cnt <= 13'h0000;
			frame <= 4'h0;
			wait_to_opp <= 1'b0;
			pend_a <= 1'b0;
			pend_b <= 1'b0;
			out_a <= 1'b0;
			out_b <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			cnt <= next_cnt;
			frame <= next_frame;
			wait_to_opp <= next_wait_to_opp;
			pend_a <= next_pend_a;
			pend_b <= next_pend_b;
			out_a <= run && (next_state == ST_OTA);
			out_b <= run && (next_state == ST_OTB);
		end
	end

	assign wave_out_a = out_a & ~in_kill[0];
	assign wave_out_b = out_b & ~in_kill[1];
endmodule
`default_nettype wire

/* File: psir_src.sv */
// retrigger and fault source model for the input pins and comparators
// assumes the bench sets the significant level and the selected source
`timescale 1ns/100ps
`default_nettype none
module psir_src (
	input wire logic clk,
	input wire logic [1:0] act,
	input wire logic [1:0] pol,
	input wire logic [1:0] src,
	output logic [1:0] pin,
	output logic [1:0] cmp
);
	logic t = 1'b0;
	// unselected line toggles, so a wrong source select shows up
	always @(posedge clk) t <= ~t;
	// significant level equals pol, idle is its inverse
	assign pin = (src & {2{t}}) | (~src & ~(act ^ pol));
	assign cmp = (~src & {2{t}}) | (src & ~(act ^ pol));
endmodule
`default_nettype wire

/* File: psir_top_properties.sv */
// checker for psir_top: exclusion, dead gaps, kill, level hold, on-time
// sees top ports only; tracks the config by watching apb writes
`timescale 1ns/100ps
`default_nettype none
`include "psir_map.vh"
module psir_chk (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`PSIR_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [1:0] fault_input_pin,
	input wire logic [1:0] comparator_out,
	input wire logic wave_out_a,
	input wire logic wave_out_b
);
	logic [3:0] ctl, ha, hb;
	logic [7:0] ica, icb;
	logic [11:0] ota;
	logic [12:0] len;
	logic ok;
	wire wr = psel & penable & pwrite & pready & ce;
	wire sa = (ica[6] ? comparator_out[0] : fault_input_pin[0]) == ica[4];
	wire sb = (icb[6] ? comparator_out[1] : fault_input_pin[1]) == icb[4];
	wire go = ctl[0] & (ctl[2:1] != `PSIR_RAMP_CENTER) & ce & !wr;
	// shadow config; hold counters restart and ok drops on writes since the config may move
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctl <= 4'h0;
			ica <= 8'h00;
			icb <= 8'h00;
			ota <= 12'h001;
			len <= 13'h0000;
			ok <= 1'b0;
			ha <= 4'h0;
			hb <= 4'h0;
		end else begin
			if (wr && paddr == `PSIR_OFF_CTRL) ctl <= pwdata[3:0];
			if (wr && paddr == `PSIR_OFF_ON_TIME) ota <= pwdata[11:0];
			if (wr && paddr == `PSIR_OFF_IN_CTRL_A) ica <= pwdata[7:0];
			if (wr && paddr == `PSIR_OFF_IN_CTRL_B) icb <= pwdata[7:0];
			len <= wave_out_a ? len + 13'h0001 : 13'h0000;
			ok <= wave_out_a ? ok & ce & !wr : 1'b1;
			ha <= (go && sa && ica[3:0] == `PSIR_IMODE_JUMP_WAIT) ? ha + {3'h0, ha != 4'hF} : 4'h0;
			hb <= (go && sb && icb[3:0] == `PSIR_IMODE_JUMP_WAIT) ? hb + {3'h0, hb != 4'hF} : 4'h0;
		end
	end
	default clocking dcb @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_no_overlap;
		!(wave_out_a && wave_out_b);
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("outputs overlap");
	property p_gap_ab;
		$fell(wave_out_a) |-> !wave_out_b;
	endproperty
	a_gap_ab: assert property (p_gap_ab) else $error("no dead time after a");
	property p_gap_ba;
		wave_out_b ##1 !wave_out_b |-> !wave_out_a;
	endproperty
	a_gap_ba: assert property (p_gap_ba) else $error("no dead time after b");
	property p_kill_a;
		ica[7] && sa |-> !wave_out_a;
	endproperty
	a_kill_a: assert property (p_kill_a) else $error("kill a missed");
	property p_kill_b;
		icb[7] && sb |-> !wave_out_b;
	endproperty
	a_kill_b: assert property (p_kill_b) else $error("kill b missed");
	property p_hold_a;
		ha >= 4'hE |-> !wave_out_a;
	endproperty
	a_hold_a: assert property (p_hold_a) else $error("a active while input a held");
	property p_hold_b;
		hb >= 4'hE |-> !wave_out_b;
	endproperty
	a_hold_b: assert property (p_hold_b) else $error("b active while input b held");
	property p_len_a;
		$fell(wave_out_a) && ok && !ctl[3] && ica == 8'h00 && icb[3:0] == 4'h0
			|-> len == (ota == 12'h000 ? 13'h0001 : {1'b0, ota});
	endproperty
	a_len_a: assert property (p_len_a) else $error("a on-time length wrong");
endmodule
bind psir_top psir_chk u_chk (.clk, .reset_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .fault_input_pin, .comparator_out, .wave_out_a, .wave_out_b);
`default_nettype wire

/* File: tb_pwm_stage_input_retrigger.sv */
// bench for psir_top: apb config, timing, input modes, kill path
// assumes psir_src on the input lines and psir_chk bound to the top
`timescale 1ns/100ps
`default_nettype none
`include "psir_map.vh"
module tb_pwm_stage_input_retrigger;
	logic clk, reset_n, ce, psel, penable, pwrite, pready, pslverr, wa, wb, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [1:0] act, pol, src, pin, cmp;
	integer bad_count, tests_run, n, g, l0, s, i, oa, ob, da, db, d;
	psir_top DUT (.clk, .reset_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .fault_input_pin(pin), .comparator_out(cmp), .wave_out_a(wa),
		.wave_out_b(wb));
	psir_src u_src (.clk, .act, .pol, .src, .pin, .cmp);
	// bench clock, 4 ns
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// one apb transfer; idle edge first so psel never toggles twice in a step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
		integer k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dat;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			bad_count++;
			report_and_stop;
		end
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// stop, load all times and input controls, then start with c
	task cfg(input logic [3:0] c, input logic [7:0] ia, input logic [7:0] ib);
		apb(1'b1, `PSIR_OFF_CTRL, 32'h0);
		apb(1'b1, `PSIR_OFF_ON_TIME, (ob << 16) | oa);
		apb(1'b1, `PSIR_OFF_DEAD_TIME, (db << 16) | da);
		apb(1'b1, `PSIR_OFF_RAMP_B_CMP, d << 12);
		apb(1'b1, `PSIR_OFF_IN_CTRL_A, {24'h0, ia});
		apb(1'b1, `PSIR_OFF_IN_CTRL_B, {24'h0, ib});
		apb(1'b1, `PSIR_OFF_CTRL, {28'h0, c});
	endtask
	// count edges until output w reads v; bounded
	task wt(input integer w, input logic v, output integer k);
		k = 0;
		while ((w ? wb : wa) !== v) begin
			@(posedge clk);
			k++;
			if (k > 3000) begin
				bad_count++;
				report_and_stop;
			end
		end
	endtask
	task pulse(input integer w, output integer k);
		wt(w, 1'b0, k);
		wt(w, 1'b1, k);
		wt(w, 1'b0, k);
	endtask
	initial begin
		seed = 32'h0000_001B;
		bad_count = 0;
		tests_run = 0;
		{reset_n, ce, psel, penable, pwrite} = 5'h08;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		{act, pol, src} = 6'h00;
		d = 0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		// reset values; stopped status with idle pins reads zero, 0x1c unmapped
		for (i = 0; i < 8; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0000_0000);
			chk(rd, (i == 1 || i == 2) ? 32'h0001_0001 : 32'h0);
			chk({31'h0, e}, i == 7);
		end
		$display("reset values done");
		// plain timing in one, two and four ramp modes, random counts
		for (i = 0; i < 3; i++) begin
			oa = rnd() % 16 + 1;
			ob = rnd() % 16 + 1;
			da = rnd() % 16 + 1;
			db = rnd() % 16 + 1;
			cfg({1'b0, i[1:0], 1'b1}, 8'h00, 8'h00);
			apb(1'b0, `PSIR_OFF_ON_TIME, 32'h0);
			chk(rd, (ob << 16) | oa);
			pulse(0, n);
			chk(n, oa);
			wt(1, 1'b1, g);
			chk(g, db);
			wt(1, 1'b0, n);
			chk(n, ob);
			wt(0, 1'b1, g);
			chk(g, da);
		end
		$display("timing done");
		// any 16 a-pulses hold d stretched ones
		d = rnd() % 15 + 1;
		oa = 6;
		g = 0;
		cfg(4'hB, 8'h00, 8'h00);
		for (i = 0; i < 16; i++) begin
			pulse(0, n);
			g += (n == 7);
		end
		chk(g, d);
		$display("fraction done");
		// mode 1 held level, both parts, polarity, source and filter
		oa = 20;
		ob = 20;
		da = 3;
		db = 3;
		d = 0;
		for (i = 0; i < 8; i++) begin
			s = i[2];
			cfg(4'h0, 8'h00, 8'h00);
			pol[s] <= i[1];
			src[s] <= i[1];
			cfg(4'h3, s ? 8'h00 : {1'b0, i[1], i[0], i[1], 4'h1}, s ? {1'b0, i[1], i[0], i[1], 4'h1} : 8'h00);
			wt(s, 1'b1, g);
			act[s] <= 1'b1;
			wt(s, 1'b0, n);
			chk(n < oa, 1);
			if (i[0]) chk(n >= l0 + 4, 1);
			l0 = n;
			repeat (30) @(posedge clk);
			chk({30'h0, wa, wb}, 0);
			act[s] <= 1'b0;
			wt(1 - s, 1'b1, g);
			wt(1 - s, 1'b0, n);
			chk(n, 20);
		end
		$display("mode 1 done");
		// mode 2: short hit, opposite part runs whole, no wait after
		for (s = 0; s < 2; s++) begin
			cfg(4'h3, s ? 8'h00 : 8'h52, s ? 8'h52 : 8'h00);
			wt(s, 1'b1, g);
			act[s] <= 1'b1;
			wt(s, 1'b0, n);
			act[s] <= 1'b0;
			wt(1 - s, 1'b1, g);
			chk(g, 3);
			wt(1 - s, 1'b0, n);
			chk(n, 20);
			wt(s, 1'b1, g);
			chk(g, 3);
		end
		$display("mode 2 done");
		// mode 8: an edge cuts the part, a level still held does not block later pulses
		for (s = 0; s < 2; s++) begin
			cfg(4'h3, s ? 8'h00 : 8'h58, s ? 8'h58 : 8'h00);
			wt(s, 1'b1, g);
			act[s] <= 1'b1;
			wt(s, 1'b0, n);
			chk(n < oa, 1);
			wt(1 - s, 1'b1, g);
			chk(g, 3);
			wt(s, 1'b1, g);
			wt(s, 1'b0, n);
			act[s] <= 1'b0;
			chk(n, 20);
		end
		$display("mode 8 done");
		// kill path with the clock enable held low
		for (s = 0; s < 2; s++) begin
			cfg(4'h3, s ? 8'h00 : 8'hD0, s ? 8'hD0 : 8'h00);
			wt(s, 1'b1, g);
			ce <= 1'b0;
			@(posedge clk);
			act[s] <= 1'b1;
			@(posedge clk);
			chk({31'h0, s ? wb : wa}, 0);
			act[s] <= 1'b0;
			@(posedge clk);
			chk({31'h0, s ? wb : wa}, 1);
			ce <= 1'b1;
		end
		$display("kill done");
		// centered mode and reserved codes leave a full pulses
		act[0] <= 1'b1;
		for (i = 0; i < 6; i++) begin
			cfg(i ? 4'h3 : 4'h7, {4'h5, i ? (i == 5 ? 4'hF : 4'h9 + i[3:0]) : 4'h1}, 8'h00);
			pulse(0, n);
			chk(n, 20);
		end
		act[0] <= 1'b0;
		$display("ignored modes done");
		// input a during on-time b: cuts only in one ramp mode
		for (i = 0; i < 2; i++) begin
			cfg(i ? 4'h3 : 4'h1, 8'h51, 8'h00);
			wt(1, 1'b1, g);
			act[0] <= 1'b1;
			wt(1, 1'b0, n);
			act[0] <= 1'b0;
			chk(n < 20, i == 0);
			wt(0, 1'b1, g);
			wt(0, 1'b0, n);
			chk(n, 20);
		end
		$display("ramp window done");
		report_and_stop;
	end
endmodule
`default_nettype wire
